// ---- hdl/lpo_panel_out.sv ----
// LCD panel pixel output: timing engine, lane mapping and APB registers.
// Assumes a pixel source on core_clk that holds a word until pix_taken.
//
// Summary of operation
// - Passive: each data line carries one on/off colour bit per pixel clock.
// - Passive: four, eight or sixteen values per pixel clock by panel type.
// - Single mono, no double-pixel: only lines 3..0 carry the screen.
// - Single mono double-pixel, or single colour: lines 7..0 carry it.
// - Double-pixel arrangement only when double_pixel_select is one.
// - Dual mono: top half on lines 3..0, bottom on 7..4, together.
// - Dual colour: top half on lines 7..0, bottom on 15..8.
// - Mono passive: each line value is one pixel per pixel clock.
// - Passive colour: successive red, green, blue values, three per pixel.
// - Pixel strobe edges shift each data word into the panel.
// - Line strobe pulses after the last pixel of every line.
// - Active: line strobe acts as horizontal sync, marking a new line.
// - Frame strobe marks the start of each new frame.
// - Passive: bias output toggles to reverse panel drive polarity.
// - Active: bias output is data enable, high only with valid pixels.
// - Active: pixel strobe toggles continuously.
// - Active: one raw 16-bit pixel per pixel clock on all lines.
// - Active: pixel words pass unchanged from the frame buffer.
// - Pixel strobe divides source clock; smallest setting gives half rate.
//
// The APB interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/100ps

module lpo_panel_out
	import lpo_pkg::*;
(
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        rstn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Pixel source
	input  wire logic [15:0] pix_data,
	input  wire logic        pix_valid,
	output logic             pix_taken,
	// Panel pins
	output logic      [15:0] panel_data_lines,
	output logic             pixel_strobe,
	output logic             line_strobe,
	output logic             frame_strobe,
	output logic             bias_out
);

	// ========================================
	// Helpers
	function automatic logic addr_hit(input logic [7:0] a);
		addr_hit = (a == ADDR_CTRL) || (a == ADDR_DIV) || (a == ADDR_HTIM) ||
			(a == ADDR_VTIM) || (a == ADDR_BIAS) || (a == ADDR_STAT);
	endfunction

	function automatic logic [15:0] lane_mask(input lpo_cfg_t c);
		if (c.active || (c.color && c.dual)) begin
			lane_mask = MASK_ALL;
		end else if (c.color || c.dual || c.double_pixel_select) begin
			lane_mask = MASK_LOW8;
		end else begin
			lane_mask = MASK_LOW4;
		end
	endfunction

	// ========================================
	// Declarations
	lpo_cfg_t    cfg;
	lpo_tim_t    tim;
	lpo_state_t  state;
	logic [7:0]  div_cnt;
	logic        ph;
	logic        next_ph;
	logic        tick;
	logic        fall;
	logic        run;
	logic [11:0] cnt;
	logic [11:0] seg_limit;
	logic        seg_end;
	logic        load;
	logic        data_end;
	logic        line_end;
	logic [11:0] line_cnt;
	logic [7:0]  bias_cnt;
	logic        underrun;
	logic        acc;
	logic        wr;
	logic [31:0] rd_mux;

	// ========================================
	// APB access
	assign acc = psel && penable && !pready;
	assign wr  = psel && penable && pready && pwrite;

	// Answer one cycle into the access phase; writes land with pready
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			pready <= 1'b0;
		end else begin
			pready <= acc;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			pslverr <= 1'b0;
		end else if (acc) begin
			pslverr <= !addr_hit(paddr);
		end else begin
			pslverr <= 1'b0;
		end
	end

	always_comb begin
		rd_mux = 32'h0000_0000;
		case (paddr)
			ADDR_CTRL: begin
				rd_mux[CTRL_EN]    = cfg.en;
				rd_mux[CTRL_ACT]   = cfg.active;
				rd_mux[CTRL_COLOR] = cfg.color;
				rd_mux[CTRL_DUAL]  = cfg.dual;
				rd_mux[CTRL_DPD]   = cfg.double_pixel_select;
			end
			ADDR_DIV: begin
				rd_mux[7:0] = tim.div;
			end
			ADDR_HTIM: begin
				rd_mux[11:0]            = tim.hpix_m1;
				rd_mux[HTIM_BLK +: 8]   = tim.hblk_m1;
				rd_mux[HTIM_LSW +: 8]   = tim.lsw_m1;
			end
			ADDR_VTIM: begin
				rd_mux[11:0] = tim.vlin_m1;
			end
			ADDR_BIAS: begin
				rd_mux[7:0] = tim.bias_m1;
			end
			ADDR_STAT: begin
				rd_mux[STAT_BUSY]      = run;
				rd_mux[STAT_BIAS]      = bias_out;
				rd_mux[STAT_UNDR]      = underrun;
				rd_mux[STAT_LINE +: 12] = line_cnt;
			end
			default: begin
				rd_mux = 32'h0000_0000;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			prdata <= 32'h0000_0000;
		end else if (acc && !pwrite) begin
			prdata <= rd_mux;
		end else begin
			prdata <= 32'h0000_0000;
		end
	end

	// ========================================
	// Configuration registers
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			cfg <= '0;
		end else if (wr && paddr == ADDR_CTRL) begin
			cfg.en <= pwdata[CTRL_EN];
			if (!cfg.en) begin
				cfg.active <= pwdata[CTRL_ACT];
				cfg.color  <= pwdata[CTRL_COLOR];
				cfg.dual   <= pwdata[CTRL_DUAL];
				cfg.double_pixel_select    <= pwdata[CTRL_DPD];
			end
		end
	end

	// Timing fields are live; change them only while disabled to avoid torn lines
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			tim.div     <= DIV_RST;
			tim.hpix_m1 <= HPIX_RST;
			tim.hblk_m1 <= HBLK_RST;
			tim.lsw_m1  <= LSW_RST;
			tim.vlin_m1 <= VLIN_RST;
			tim.bias_m1 <= BIAS_RST;
		end else if (wr) begin
			case (paddr)
				ADDR_DIV: begin
					tim.div <= pwdata[7:0];
				end
				ADDR_HTIM: begin
					tim.hpix_m1 <= pwdata[11:0];
					tim.hblk_m1 <= pwdata[HTIM_BLK +: 8];
					tim.lsw_m1  <= pwdata[HTIM_LSW +: 8];
				end
				ADDR_VTIM: begin
					tim.vlin_m1 <= pwdata[11:0];
				end
				ADDR_BIAS: begin
					tim.bias_m1 <= pwdata[7:0];
				end
				default: begin
					tim.div <= tim.div;
				end
			endcase
		end
	end

	// ========================================
	// Pixel clock divider
	assign run  = (state != ST_IDLE);
	// divide by two times the setting plus two
	assign tick = (div_cnt == tim.div);
	assign fall = tick && ph;

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			div_cnt <= 8'h00;
		end else if (!run || tick) begin
			div_cnt <= 8'h00;
		end else begin
			div_cnt <= div_cnt + 8'h01;
		end
	end

	always_comb begin
		next_ph = ph;
		if (!run) begin
			next_ph = 1'b0;
		end else if (tick) begin
			next_ph = !ph;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			ph <= 1'b0;
		end else begin
			ph <= next_ph;
		end
	end

	// panel samples on the rising strobe edge; data moves on the falling one
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			pixel_strobe <= 1'b0;
		end else begin
			// free-running in active mode, gated to the data window otherwise
			pixel_strobe <= run && next_ph && (cfg.active || state == ST_DATA);
		end
	end

	// ========================================
	// Line sequencer
	always_comb begin
		case (state)
			ST_BLANK: seg_limit = {4'h0, tim.hblk_m1};
			ST_DATA:  seg_limit = tim.hpix_m1;
			ST_LSTRB: seg_limit = {4'h0, tim.lsw_m1};
			default:  seg_limit = 12'h000;
		endcase
	end

	assign seg_end  = (cnt == seg_limit);
	assign load     = fall && ((state == ST_BLANK && seg_end) ||
		(state == ST_DATA && !seg_end));
	assign data_end = fall && state == ST_DATA && seg_end;
	assign line_end = fall && state == ST_LSTRB && seg_end;

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			state <= ST_IDLE;
			cnt   <= 12'h000;
		end else if (!cfg.en) begin
			state <= ST_IDLE;
			cnt   <= 12'h000;
		end else begin
			case (state)
				ST_IDLE: begin
					state <= ST_BLANK;
					cnt   <= 12'h000;
				end
				ST_BLANK, ST_DATA, ST_LSTRB: begin
					if (fall && seg_end) begin
						cnt <= 12'h000;
						if (state == ST_BLANK) begin
							state <= ST_DATA;
						end else if (state == ST_DATA) begin
							state <= ST_LSTRB;
						end else begin
							state <= ST_BLANK;
						end
					end else if (fall) begin
						cnt <= cnt + 12'h001;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// ========================================
	// Data lanes
	// source delivers dithered bits, one colour bit per line
	// source orders colour bits red, green, blue
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			panel_data_lines <= 16'h0000;
		end else if (!run || data_end) begin
			panel_data_lines <= 16'h0000;
		end else if (load) begin
			// active passes the raw word unchanged
			// lanes outside the mask forced low
			if (pix_valid) begin
				panel_data_lines <= pix_data & lane_mask(cfg);
			end else begin
				panel_data_lines <= 16'h0000;
			end
		end
	end

	// Taken one cycle after capture; fall ticks are at least two cycles apart
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			pix_taken <= 1'b0;
		end else begin
			pix_taken <= load && pix_valid;
		end
	end

	// Starved source shows as blank pixels; sticky, write one to clear, set wins
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			underrun <= 1'b0;
		end else if (load && !pix_valid) begin
			underrun <= 1'b1;
		end else if (wr && paddr == ADDR_STAT && pwdata[STAT_UNDR]) begin
			underrun <= 1'b0;
		end
	end

	// ========================================
	// Line and frame strobes
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			line_strobe <= 1'b0;
		end else if (!run || line_end) begin
			line_strobe <= 1'b0;
		end else if (data_end) begin
			// same pulse leads the next line as horizontal sync
			line_strobe <= 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			frame_strobe <= 1'b0;
		end else if (!run || line_end) begin
			frame_strobe <= 1'b0;
		end else if (data_end && line_cnt == tim.vlin_m1) begin
			// marks the line pulse that opens a new frame
			frame_strobe <= 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			line_cnt <= 12'h000;
		end else if (!run) begin
			line_cnt <= 12'h000;
		end else if (line_end) begin
			line_cnt <= (line_cnt == tim.vlin_m1) ? 12'h000 : line_cnt + 12'h001;
		end
	end

	// ========================================
	// Bias / data enable
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			bias_cnt <= 8'h00;
		end else if (!run) begin
			bias_cnt <= 8'h00;
		end else if (line_end) begin
			bias_cnt <= (bias_cnt == tim.bias_m1) ? 8'h00 : bias_cnt + 8'h01;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			bias_out <= 1'b0;
		end else if (!run) begin
			bias_out <= 1'b0;
		end else if (cfg.active) begin
			// data enable tracks valid pixels on the lanes
			if (load) begin
				bias_out <= pix_valid;
			end else if (data_end) begin
				bias_out <= 1'b0;
			end
		end else if (line_end && bias_cnt == tim.bias_m1) begin
			// polarity flip every bias_m1 plus one lines
			bias_out <= !bias_out;
		end
	end

endmodule // lpo_panel_out

// ---- include/lpo_pkg.sv ----
// Constants and carrier types for the LCD panel pixel output block.
// Assumes an APB slave on one 40 MHz core clock with 32-bit data.
package lpo_pkg;

	// ========================================
	// Register map (byte addresses)
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_DIV  = 8'h04;
	localparam logic [7:0] ADDR_HTIM = 8'h08;
	localparam logic [7:0] ADDR_VTIM = 8'h0c;
	localparam logic [7:0] ADDR_BIAS = 8'h10;
	localparam logic [7:0] ADDR_STAT = 8'h14;

	// ========================================
	// Field positions
	localparam int CTRL_EN    = 0;
	localparam int CTRL_ACT   = 1;
	localparam int CTRL_COLOR = 2;
	localparam int CTRL_DUAL  = 3;
	localparam int CTRL_DPD   = 4;
	localparam int HTIM_BLK   = 16;
	localparam int HTIM_LSW   = 24;
	localparam int STAT_BUSY  = 0;
	localparam int STAT_BIAS  = 1;
	localparam int STAT_UNDR  = 2;
	localparam int STAT_LINE  = 16;

	// ========================================
	// Reset values
	localparam logic [7:0]  DIV_RST  = 8'h00;
	localparam logic [11:0] HPIX_RST = 12'h13f;
	localparam logic [7:0]  HBLK_RST = 8'h07;
	localparam logic [7:0]  LSW_RST  = 8'h00;
	localparam logic [11:0] VLIN_RST = 12'h0ef;
	localparam logic [7:0]  BIAS_RST = 8'h0d;

	// ========================================
	// Lane masks per panel arrangement
	localparam logic [15:0] MASK_ALL  = 16'hffff;
	localparam logic [15:0] MASK_LOW8 = 16'h00ff;
	localparam logic [15:0] MASK_LOW4 = 16'h000f;

	// ========================================
	// Carrier types
	typedef struct packed {
		logic en;
		logic active;
		logic color;
		logic dual;
		logic double_pixel_select;
	} lpo_cfg_t;

	typedef struct packed {
		logic [7:0]  div;
		logic [11:0] hpix_m1;
		logic [7:0]  hblk_m1;
		logic [7:0]  lsw_m1;
		logic [11:0] vlin_m1;
		logic [7:0]  bias_m1;
	} lpo_tim_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_BLANK,
		ST_DATA,
		ST_LSTRB
	} lpo_state_t;

endpackage

// ---- dv/lpo_panel_model.sv ----
// Panel model: shifts a word on each pixel strobe rise, counts lines.
// Assumes core clock sampling; active panels latch only with DE high.
`timescale 1ns/100ps
module lpo_panel_model
	import lpo_pkg::*;
(
	// Clock, reset, mode
	input  wire logic        core_clk,
	input  wire logic        rstn,
	input  wire logic        active,
	// Panel pins
	input  wire logic [15:0] panel_data_lines,
	input  wire logic        pixel_strobe,
	input  wire logic        line_strobe,
	input  wire logic        frame_strobe,
	input  wire logic        bias_out,
	// Observations
	output logic             cap,
	output logic      [15:0] word,
	output logic             line_ev,
	output logic             frame_ev,
	output logic      [11:0] n_words,
	output logic      [11:0] n_lines
);
	// ========================================
	// Shift and line logic
	logic        ps_q;
	logic        ls_q;
	logic        sh;
	logic [11:0] wc;
	logic [11:0] lc;
	assign sh = pixel_strobe & !ps_q & (!active | bias_out);
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			{ps_q, ls_q, cap, line_ev, frame_ev} <= 5'h00;
			{word, wc, lc, n_words, n_lines} <= '0;
		end else begin
			ps_q <= pixel_strobe;
			ls_q <= line_strobe;
			word <= panel_data_lines;
			cap <= sh;
			line_ev <= line_strobe & !ls_q;
			frame_ev <= line_strobe & !ls_q & frame_strobe;
			wc <= wc + 12'(sh);
			if (line_strobe & !ls_q) begin
				n_words <= wc;
				wc <= 12'h000;
				lc <= frame_strobe ? 12'h000 : lc + 12'h001;
				if (frame_strobe)
					n_lines <= lc + 12'h001;
			end
		end
	end
endmodule // lpo_panel_model

// ---- dv/lpo_panel_out_props.sv ----
// Checker on the panel output ports; mirrors mode bits from APB writes.
// Assumes timing and mode registers change only while output is off.
`timescale 1ns/100ps
module lpo_panel_out_props
	import lpo_pkg::*;
(
	// Clock and reset
	input wire logic        core_clk,
	input wire logic        rstn,
	// APB
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	// Panel
	input wire logic [15:0] panel_data_lines,
	input wire logic        pixel_strobe,
	input wire logic        line_strobe,
	input wire logic        frame_strobe,
	input wire logic        bias_out
);
	// ========================================
	// Register shadows
	logic        wr;
	logic        en;
	logic [4:0]  c;
	logic [7:0]  dv;
	logic [7:0]  bs;
	logic [15:0] mask;
	assign wr = psel & penable & pready & pwrite;
	assign en = c[CTRL_EN];
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			c <= 5'h00;
			dv <= DIV_RST;
			bs <= BIAS_RST;
		end else if (wr) begin
			// Mode bits frozen while running
			if (paddr == ADDR_CTRL)
				c <= en ? {c[4:1], pwdata[0]} : pwdata[4:0];
			if (paddr == ADDR_DIV)
				dv <= pwdata[7:0];
			if (paddr == ADDR_BIAS)
				bs <= pwdata[7:0];
		end
	end
	assign mask = (c[CTRL_ACT] | (c[CTRL_COLOR] & c[CTRL_DUAL])) ? MASK_ALL :
		(c[CTRL_COLOR] | c[CTRL_DUAL] | c[CTRL_DPD]) ? MASK_LOW8 : MASK_LOW4;
	// ========================================
	// Properties
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);
	AST_LANE_MASK:
		assert property ((panel_data_lines & ~mask) == 16'h0000) else $error("Lane misuse");
	AST_FRAME_IN_LINE:
		assert property (frame_strobe |-> line_strobe) else $error("Lone frame strobe");
	AST_PSV_LINE:
		assert property (!c[CTRL_ACT] && line_strobe |-> !pixel_strobe) else $error("Strobe in pulse");
	AST_DE_LINE:
		assert property (c[CTRL_ACT] && line_strobe |-> !bias_out) else $error("DE in line pulse");
	AST_HALF_RATE:
		assert property (dv == 8'h00 && $rose(pixel_strobe) |=> $fell(pixel_strobe))
		else $error("Strobe too slow");
	AST_HOLD_DATA:
		assert property (pixel_strobe && !$rose(pixel_strobe) |-> $stable(panel_data_lines))
		else $error("Data moved early");
	AST_BIAS_FLIP:
		assert property (!c[CTRL_ACT] && en && !wr && bs == 8'h00 && $fell(line_strobe)
			|-> bias_out != $past(bias_out)) else $error("Bias did not flip");
	AST_ACT_RUN:
		assert property (c[CTRL_ACT] && en && $past(en, 4) && !wr && dv == 8'h00
			|-> pixel_strobe != $past(pixel_strobe)) else $error("Strobe stalled");
endmodule // lpo_panel_out_props

bind lpo_panel_out lpo_panel_out_props lpo_panel_out_props_i (.*);

// ---- dv/lpo_panel_out_tb_top.sv ----
// Self-checking bench: register resets, then every panel mode in turn.
// Assumes the panel model and checker are compiled before this file.
`timescale 1ns/100ps
module lpo_panel_out_tb_top
	import lpo_pkg::*;
;
	logic        core_clk, rstn, mrstn, psel, penable, pwrite, pix_valid, act_m, stall;
	logic        pready, pslverr, pix_taken, pixel_strobe, line_strobe, frame_strobe;
	logic        bias_out, cap, line_ev, frame_ev, er;
	logic [4:0]  md;
	logic [7:0]  paddr;
	logic [11:0] n_words, n_lines;
	logic [15:0] pix_data, panel_data_lines, word, mask, mw;
	logic [31:0] pwdata, prdata, rd;
	logic [31:0] seed = 32'he7e6f2a9;
	logic [15:0] exp_q[$];
	logic [4:0]  modes[7] = '{5'h00, 5'h10, 5'h08, 5'h04, 5'h0c, 5'h02, 5'h02};
	logic [31:0] rv[7] = '{0, 0, {LSW_RST, HBLK_RST, 4'h0, HPIX_RST}, 32'(VLIN_RST),
		32'(BIAS_RST), 0, 0};
	int          n_errors = 0;
	int          n_tests = 0;
	int          nf = 0;
	lpo_panel_out lpo_panel_out_i (.*);
	lpo_panel_model lpo_panel_model_i (.core_clk, .rstn(mrstn), .active(act_m),
		.panel_data_lines, .pixel_strobe, .line_strobe, .frame_strobe, .bias_out,
		.cap, .word, .line_ev, .frame_ev, .n_words, .n_lines);
	// ========================================
	// Helpers
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [15:0] lanes(input logic [4:0] m);
		if (m[CTRL_ACT] || (m[CTRL_COLOR] && m[CTRL_DUAL])) return 16'hffff;
		if (m[CTRL_COLOR] || m[CTRL_DUAL] || m[CTRL_DPD]) return 16'h00ff;
		return 16'h000f;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic print_verdict();
		if (n_errors == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge core_clk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 50) begin
			n_errors++;
			print_verdict();
		end
	endtask
	// ========================================
	// Pixel source and panel checks
	always @(posedge core_clk) begin
		if (pix_taken === 1'b1) begin
			exp_q.push_back(pix_data & mask);
			pix_data <= 16'(rnd());
			pix_valid <= !stall | seed[7];
		end else
			pix_valid <= 1'b1;
		if (cap === 1'b1) begin
			mw = (exp_q.size() > 0) ? exp_q.pop_front() : 16'hdead;
			chk(32'(word), 32'(mw));
		end
		if (line_ev === 1'b1 && !stall)
			chk(32'(n_words), 32'h4);
		if (frame_ev === 1'b1) begin
			chk(32'(n_lines), 32'h2);
			nf++;
		end
	end
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	// ========================================
	// Main sequence
	initial begin
		{rstn, mrstn, psel, penable, pwrite, act_m, stall} = 7'h00;
		{paddr, pwdata, pix_data, mask} = '0;
		pix_valid = 1'b1;
		repeat (3) @(posedge core_clk);
		rstn <= 1'b1;
		for (int i = 0; i < 7; i++) begin
			apb(1'b0, 8'(i * 4), 32'h0);
			chk(rd, rv[i]);
			chk(32'(er), 32'(i == 6));
		end
		for (int m = 0; m < 7; m++) begin
			md = modes[m];
			stall = (m == 6);
			act_m = md[CTRL_ACT];
			mask = lanes(md);
			exp_q.delete();
			nf = 0;
			apb(1'b1, ADDR_DIV, stall ? 32'h0 : rnd() % 2);
			// Model leaves reset only after a full bus transfer in reset
			mrstn <= 1'b1;
			apb(1'b1, ADDR_HTIM, 32'h3);
			apb(1'b1, ADDR_VTIM, 32'h1);
			apb(1'b1, ADDR_BIAS, 32'h0);
			apb(1'b1, ADDR_CTRL, {27'h0, md} | 32'h1);
			apb(1'b1, ADDR_CTRL, {27'h0, ~md} | 32'h1);
			apb(1'b0, ADDR_CTRL, 32'h0);
			chk(rd, {27'h0, md} | 32'h1);
			for (int k = 0; k < 3000 && nf < 3; k++)
				@(posedge core_clk);
			if (nf < 3) begin
				n_errors++;
				print_verdict();
			end
			apb(1'b1, ADDR_CTRL, 32'h0);
			// Tail pixel still reaches the model after the disable lands
			repeat (8) @(posedge core_clk);
			mrstn <= 1'b0;
			if (stall) begin
				apb(1'b0, ADDR_STAT, 32'h0);
				chk(rd & 32'h4, 32'h4);
				apb(1'b1, ADDR_STAT, 32'h4);
				apb(1'b0, ADDR_STAT, 32'h0);
				chk(rd & 32'h4, 32'h0);
			end
		end
		print_verdict();
	end
endmodule // lpo_panel_out_tb_top
